// File: core/psch_consts.svh
// constants for the pin state command handler: offsets, codes, encodings
`ifndef PSCH_CONSTS_SVH
`define PSCH_CONSTS_SVH

// register byte offsets
`define PSCH_OFF_CMD 8'h00
`define PSCH_OFF_STATUS 8'h04
`define PSCH_OFF_QUERY 8'h08
`define PSCH_OFF_ACCESS 8'h0c
`define PSCH_OFF_DATA0 8'h10
`define PSCH_OFF_DATA1 8'h14
`define PSCH_OFF_DATA2 8'h18
`define PSCH_OFF_DATA3 8'h1c

// operation codes in the command register
`define PSCH_OP_PROVISION 3'h0
`define PSCH_OP_CHANGE 3'h1
`define PSCH_OP_DISABLE 3'h2
`define PSCH_OP_ENABLE 3'h3
`define PSCH_OP_QUERY 3'h4
`define PSCH_OP_UNBLOCK 3'h5

// result codes
`define PSCH_RES_OK 3'h0
`define PSCH_RES_WRONG 3'h1
`define PSCH_RES_REFUSED 3'h2
`define PSCH_RES_BAD_PARAM 3'h3
`define PSCH_RES_BLOCKED 3'h4

// access verdicts
`define PSCH_ACC_VERIFY 2'h0
`define PSCH_ACC_ALWAYS 2'h1
`define PSCH_ACC_ALTERNATE 2'h2
`define PSCH_ACC_NEVER 2'h3

// parameter encodings
`define PSCH_RETRY_INIT 2'h3
`define PSCH_RETRY_LAST 2'h1
`define PSCH_LC_CHANGE 8'h10
`define PSCH_LC_PIN 8'h08
`define PSCH_P1_NONE 8'h00
`define PSCH_P1_RESERVED 8'h01
`define PSCH_QUAL_USE 8'h08
`define PSCH_QUAL_NONE 8'h00
`define PSCH_REF_NONE 5'h00

// field positions in the command register
`define PSCH_CMD_OP 2:0
`define PSCH_CMD_P1 15:8
`define PSCH_CMD_P2 23:16
`define PSCH_CMD_LC 31:24

// axi responses
`define PSCH_RESP_OKAY 2'h0
`define PSCH_RESP_SLVERR 2'h2

`endif

// File: core/psch_pkg.sv
// types shared by the pin state command handler files
package psch_pkg;

    // one stored key entry
    typedef struct packed {
        logic [63:0] pin;
        logic [1:0] retry;
        logic disabled;
        logic blocked;
        logic [4:0] alt_ref;
        logic [7:0] qual;
    } psch_entry_t;

    // command sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RD = 3'b001,
        S_EXEC = 3'b010,
        S_ALT_RD = 3'b011,
        S_ALT_MOD = 3'b100,
        S_QRY_B = 3'b101,
        S_QRY_END = 3'b110,
        S_DONE = 3'b111
    } psch_state_t;

endpackage

// File: core/psch_key_store.sv
// key store: retained pin entries with registered read data
`timescale 1ns/1ps

module psch_key_store
    import psch_pkg::*;
(
    input wire logic aclk,
    input wire logic [5:0] raddr,
    output psch_entry_t rdata,
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire psch_entry_t wdata
);

    // no reset: contents survive aresetn like card storage
    psch_entry_t mem [0:63];

    // write port and registered read port
    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// File: core/psch_handler.sv
// pin state command handler: change, disable and enable pin over axi4-lite
`timescale 1ns/1ps
`include "psch_consts.svh"

module psch_handler
    import psch_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic security_environment_revalidate
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // byte-lane merge for register writes
    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // access verdict for a file guarded by one key entry
    function automatic logic [1:0] verdict_of(input psch_entry_t e);
        logic [1:0] v;
        v = `PSCH_ACC_VERIFY;
        if (e.disabled && e.alt_ref != `PSCH_REF_NONE)
        begin
            v = `PSCH_ACC_ALTERNATE;
        end
        else if (e.disabled)
        begin
            v = `PSCH_ACC_ALWAYS;
        end
        else if (e.blocked)
        begin
            v = `PSCH_ACC_NEVER;
        end
        return v;
    endfunction

    // ************************************************************
    // register storage and bus decode
    // ************************************************************

    logic [31:0] cmd;
    logic [31:0] query;
    logic [31:0] data_w [0:3];
    logic [2:0] result;
    logic [1:0] st_retry;
    logic st_disabled;
    logic st_blocked;
    logic [1:0] acc_verdict;
    logic [4:0] acc_alt;
    logic [7:0] acc_qual;
    logic start;
    psch_state_t state;
    logic [5:0] cur_addr;
    logic [1:0] verdict_a;
    logic [7:0] alt_qual;
    logic se_pending;
    psch_entry_t rd_ent;

    // write channel decode
    wire aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire busy = (state != S_IDLE) || start;
    wire w_cmd = (s_axi_awaddr == `PSCH_OFF_CMD);
    wire w_query = (s_axi_awaddr == `PSCH_OFF_QUERY);
    wire w_data = ({s_axi_awaddr[7:4], 4'h0} == `PSCH_OFF_DATA0) && (s_axi_awaddr[1:0] == 2'h0);
    wire [1:0] w_dsel = s_axi_awaddr[3:2];
    wire w_ok = (w_cmd || w_query || w_data) && !busy;

    // read channel decode
    wire ar_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire [31:0] status_word = {24'h000000, st_blocked, st_disabled, st_retry, result, busy};
    wire [31:0] access_word = {8'h00, acc_qual, 3'h0, acc_alt, 6'h00, acc_verdict};
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        rd_word = 32'h00000000;
        if (s_axi_araddr == `PSCH_OFF_CMD)
            rd_word = cmd;
        else if (s_axi_araddr == `PSCH_OFF_STATUS)
            rd_word = status_word;
        else if (s_axi_araddr == `PSCH_OFF_QUERY)
            rd_word = query;
        else if (s_axi_araddr == `PSCH_OFF_ACCESS)
            rd_word = access_word;
        else if ({s_axi_araddr[7:4], 4'h0} == `PSCH_OFF_DATA0 && s_axi_araddr[1:0] == 2'h0)
            rd_word = data_w[s_axi_araddr[3:2]];
        else
            rd_hit = 1'b0;
    end

    // write handshake, response and register stores
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PSCH_RESP_OKAY;
            cmd <= 32'h00000000;
            query <= 32'h00000000;
            start <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                data_w[i] <= 32'h00000000;
            end
        end
        else
        begin
            s_axi_awready <= aw_go;
            s_axi_wready <= aw_go;
            start <= aw_go && w_ok && w_cmd;
            if (aw_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_ok ? `PSCH_RESP_OKAY : `PSCH_RESP_SLVERR;
                if (w_ok && w_cmd)
                    cmd <= merge_strb(cmd, s_axi_wdata, s_axi_wstrb);
                if (w_ok && w_query)
                    query <= merge_strb(query, s_axi_wdata, s_axi_wstrb);
                if (w_ok && w_data)
                    data_w[w_dsel] <= merge_strb(data_w[w_dsel], s_axi_wdata, s_axi_wstrb);
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read handshake and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PSCH_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ar_go;
            if (ar_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `PSCH_RESP_OKAY : `PSCH_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // command field decode and parameter checks
    // ************************************************************

    wire [2:0] op = cmd[`PSCH_CMD_OP];
    wire [7:0] p1 = cmd[`PSCH_CMD_P1];
    wire [7:0] p2 = cmd[`PSCH_CMD_P2];
    wire [7:0] lc = cmd[`PSCH_CMD_LC];
    wire [5:0] key_idx = {p2[7], p2[4:0]};
    wire p2_ok = (p2[4:0] != `PSCH_REF_NONE) && (p2[6:5] == 2'h0);
    wire p1_alt = p1[7];
    wire p1_dis_ok = (p1[6:5] == 2'h0) && (p1 != `PSCH_P1_RESERVED) &&
                     (p1_alt ? (p1[4:0] != `PSCH_REF_NONE) : (p1 == `PSCH_P1_NONE));
    wire [63:0] first_pin = {data_w[1], data_w[0]};
    wire [63:0] second_pin = {data_w[3], data_w[2]};
    wire pin_match = (rd_ent.pin == first_pin);
    wire [5:0] qa = query[5:0];
    wire [5:0] qb = query[13:8];
    wire q_two = query[16];

    // encodings accepted per operation
    logic params_ok;
    always_comb
    begin
        case (op)
            `PSCH_OP_CHANGE: params_ok = p2_ok && p1 == `PSCH_P1_NONE && lc == `PSCH_LC_CHANGE;
            `PSCH_OP_DISABLE: params_ok = p2_ok && p1_dis_ok && lc == `PSCH_LC_PIN;
            `PSCH_OP_ENABLE: params_ok = p2_ok && p1 == `PSCH_P1_NONE && lc == `PSCH_LC_PIN;
            `PSCH_OP_PROVISION: params_ok = p2_ok;
            `PSCH_OP_UNBLOCK: params_ok = p2_ok;
            `PSCH_OP_QUERY: params_ok = 1'b1;
            default: params_ok = 1'b0;
        endcase
    end

    // ************************************************************
    // entry update for one command
    // ************************************************************

    psch_entry_t next_ent;
    logic [2:0] next_res;
    logic exec_we;
    logic alt_go;
    logic [4:0] alt_target;
    logic se_hit;
    logic fail;
    always_comb
    begin
        next_ent = rd_ent;
        next_res = `PSCH_RES_OK;
        exec_we = 1'b0;
        alt_go = 1'b0;
        alt_target = p1[4:0];
        se_hit = 1'b0;
        fail = 1'b0;
        case (op)
            `PSCH_OP_PROVISION:
            begin
                next_ent.pin = first_pin;
                next_ent.retry = `PSCH_RETRY_INIT;
                next_ent.disabled = 1'b0;
                next_ent.blocked = 1'b0;
                next_ent.alt_ref = `PSCH_REF_NONE;
                next_ent.qual = `PSCH_QUAL_NONE;
                exec_we = 1'b1;
            end
            `PSCH_OP_UNBLOCK:
            begin
                next_ent.blocked = 1'b0;
                next_ent.retry = `PSCH_RETRY_INIT;
                next_ent.disabled = 1'b0;
                exec_we = 1'b1;
            end
            `PSCH_OP_CHANGE:
            begin
                if (rd_ent.disabled || rd_ent.blocked)
                    next_res = `PSCH_RES_REFUSED;
                else if (pin_match)
                begin
                    next_ent.retry = `PSCH_RETRY_INIT;
                    next_ent.pin = second_pin;
                    exec_we = 1'b1;
                end
                else
                    fail = 1'b1;
            end
            `PSCH_OP_DISABLE:
            begin
                if (rd_ent.disabled || rd_ent.blocked)
                    next_res = `PSCH_RES_REFUSED;
                else if (pin_match)
                begin
                    next_ent.retry = `PSCH_RETRY_INIT;
                    next_ent.disabled = 1'b1;
                    next_ent.alt_ref = p1_alt ? p1[4:0] : `PSCH_REF_NONE;
                    alt_go = p1_alt;
                    exec_we = 1'b1;
                    se_hit = 1'b1;
                end
                else
                    fail = 1'b1;
            end
            `PSCH_OP_ENABLE:
            begin
                if (!rd_ent.disabled || rd_ent.blocked)
                    next_res = `PSCH_RES_REFUSED;
                else if (pin_match)
                begin
                    next_ent.retry = `PSCH_RETRY_INIT;
                    next_ent.disabled = 1'b0;
                    next_ent.alt_ref = `PSCH_REF_NONE;
                    alt_go = (rd_ent.alt_ref != `PSCH_REF_NONE);
                    alt_target = rd_ent.alt_ref;
                    exec_we = 1'b1;
                    se_hit = 1'b1;
                end
                else
                    fail = 1'b1;
            end
            default:
            begin
                next_res = `PSCH_RES_OK;
            end
        endcase
        // wrong presentation: count down, stop at zero, block on the last
        if (fail)
        begin
            exec_we = 1'b1;
            if (rd_ent.retry != 2'h0)
                next_ent.retry = rd_ent.retry - 2'h1;
            if (rd_ent.retry <= `PSCH_RETRY_LAST)
            begin
                next_ent.blocked = 1'b1;
                next_res = `PSCH_RES_BLOCKED;
            end
            else
                next_res = `PSCH_RES_WRONG;
        end
    end

    // replacement key entry with its qualifier rewritten
    psch_entry_t alt_ent;
    always_comb
    begin
        alt_ent = rd_ent;
        alt_ent.qual = alt_qual;
    end

    // two-key verdict: any disabled key opens the file
    wire [1:0] verdict_b = verdict_of(rd_ent);
    wire any_open = (verdict_a == `PSCH_ACC_ALWAYS) || (verdict_a == `PSCH_ACC_ALTERNATE) ||
                    (verdict_b == `PSCH_ACC_ALWAYS) || (verdict_b == `PSCH_ACC_ALTERNATE);

    // store port selection
    wire mem_we = (state == S_EXEC && op != `PSCH_OP_QUERY && exec_we) || (state == S_ALT_MOD);
    wire psch_entry_t mem_wdata = (state == S_ALT_MOD) ? alt_ent : next_ent;

    psch_key_store u_store (
        .aclk(aclk),
        .raddr(cur_addr),
        .rdata(rd_ent),
        .we(mem_we),
        .waddr(cur_addr),
        .wdata(mem_wdata)
    );

    // ************************************************************
    // command sequencer
    // ************************************************************

    // read entry, apply command, then touch the replacement key
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= S_IDLE;
            cur_addr <= 6'h00;
            result <= `PSCH_RES_OK;
            st_retry <= 2'h0;
            st_disabled <= 1'b0;
            st_blocked <= 1'b0;
            acc_verdict <= `PSCH_ACC_VERIFY;
            acc_alt <= `PSCH_REF_NONE;
            acc_qual <= `PSCH_QUAL_NONE;
            verdict_a <= `PSCH_ACC_VERIFY;
            alt_qual <= `PSCH_QUAL_NONE;
            se_pending <= 1'b0;
            security_environment_revalidate <= 1'b0;
        end
        else
        begin
            security_environment_revalidate <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (start && !params_ok)
                        result <= `PSCH_RES_BAD_PARAM;
                    else if (start)
                    begin
                        cur_addr <= (op == `PSCH_OP_QUERY) ? qa : key_idx;
                        state <= S_RD;
                    end
                end
                S_RD:
                    state <= S_EXEC;
                S_EXEC:
                begin
                    if (op == `PSCH_OP_QUERY)
                    begin
                        verdict_a <= verdict_of(rd_ent);
                        acc_verdict <= verdict_of(rd_ent);
                        acc_alt <= rd_ent.alt_ref;
                        acc_qual <= rd_ent.qual;
                        result <= `PSCH_RES_OK;
                        cur_addr <= qb;
                        state <= q_two ? S_QRY_B : S_DONE;
                    end
                    else
                    begin
                        result <= next_res;
                        st_retry <= next_ent.retry;
                        st_disabled <= next_ent.disabled;
                        st_blocked <= next_ent.blocked;
                        se_pending <= se_hit;
                        alt_qual <= (op == `PSCH_OP_DISABLE) ? `PSCH_QUAL_USE : `PSCH_QUAL_NONE;
                        cur_addr <= {1'b0, alt_target}; // replacement keys are global
                        state <= alt_go ? S_ALT_RD : S_DONE;
                    end
                end
                S_ALT_RD:
                    state <= S_ALT_MOD;
                S_ALT_MOD:
                    state <= S_DONE;
                S_QRY_B:
                    state <= S_QRY_END;
                S_QRY_END:
                begin
                    acc_alt <= `PSCH_REF_NONE;
                    acc_qual <= `PSCH_QUAL_NONE;
                    if (any_open)
                        acc_verdict <= `PSCH_ACC_ALWAYS;
                    else if (verdict_a == `PSCH_ACC_NEVER || verdict_b == `PSCH_ACC_NEVER)
                        acc_verdict <= `PSCH_ACC_NEVER;
                    else
                        acc_verdict <= `PSCH_ACC_VERIFY;
                    state <= S_DONE;
                end
                S_DONE:
                begin
                    security_environment_revalidate <= se_pending;
                    se_pending <= 1'b0;
                    state <= S_IDLE;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end

endmodule

// File: testbench/psch_monitor.sv
// checker: bus handshake timing and revalidate pulse of the handler
`timescale 1ns/1ps
// ***
// handshake and pulse properties
// ***
module psch_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic security_environment_revalidate
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // write taken, then answered for exactly one cycle
    sequence s_wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence s_wr_ans;
        s_axi_awready && s_axi_wready && s_axi_bvalid ##1 !s_axi_awready && !s_axi_wready;
    endsequence
    a_wr_answer: assert property (s_wr_take |=> s_wr_ans)
        else $error("write not answered");
    a_rd_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=>
        s_axi_arready && s_axi_rvalid ##1 !s_axi_arready) else $error("read not answered");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("response not held");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("response held too long");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held too long");
    a_aw_cause: assert property ($rose(s_axi_awready) |->
        $past(s_axi_awvalid) && $past(s_axi_wvalid)) else $error("write taken unasked");
    a_reval_pulse: assert property (security_environment_revalidate |=>
        !security_environment_revalidate) else $error("revalidate too long");
endmodule

// File: testbench/psch_terminal.sv
// terminal model: bus master that issues command words
`timescale 1ns/1ps
// ***
// bus master
// ***
module psch_terminal (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr = 8'h00,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [7:0] s_axi_araddr = 8'h00,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    int lag = 0;
    // write: hold until taken, released lines flip, then slow or prompt response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        repeat (lag) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    // read: same discipline on the read channels
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        repeat (lag) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// File: testbench/tb_psch_handler.sv
// bench: pin command sequences against a behavioural key model
`timescale 1ns/1ps
`include "psch_consts.svh"
// ***
// stimulus, key model and verdict
// ***
module tb_psch_handler;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, security_environment_revalidate;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, sts, seed = 32'h3390;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [63:0] pin [64];
    logic [1:0] retry [64];
    logic dis [64], blk [64];
    int n_errors = 0, num_checks = 0, nrev = 0, nexp = 0;
    logic [26:0] badp [7] = '{27'h1000108, 27'h1010110, 27'h2010108, 27'h2c10108,
        27'h2800108, 27'h2000110, 27'h6002108};
    psch_handler psch_handler_i (.*);
    psch_terminal psch_terminal_i (.*);
    // clock and revalidate pulse counter
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk)
        if (security_environment_revalidate === 1'b1)
            nrev++;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one command: data words, command word, poll, then model and compare
    task automatic cmd(input logic [2:0] op, input logic [7:0] p1, p2, lc,
        input logic [63:0] pa, input logic [63:0] pb = 64'h0);
        logic [127:0] dat;
        logic [6:0] m;
        logic bad;
        int k, ex;
        dat = {pb, pa};
        k = {p2[7], p2[4:0]};
        ex = 0;
        bad = op > 5 || (op != 4 && (p2[4:0] == 0 || p2[6:5] != 0));
        if (op == 1 || op == 3)
            bad |= p1 != 0 || lc != ((op == 1) ? 8'h10 : 8'h08);
        if (op == 2)
            bad |= lc != 8'h08 || p1[6:5] != 0 || (p1[7] ? p1[4:0] == 0 : p1 != 0);
        psch_terminal_i.lag = rnd() % 3;
        for (int i = 0; i < 4; i++)
            psch_terminal_i.wr(8'(`PSCH_OFF_DATA0 + 4 * i), dat[32 * i +: 32], resp);
        psch_terminal_i.wr(`PSCH_OFF_CMD, {lc, p2, p1, 5'h00, op}, resp);
        do psch_terminal_i.rd(`PSCH_OFF_STATUS, sts, resp); while (sts[0] !== 1'b0);
        if (op == 4)
            return;
        if (bad)
            ex = 3;
        else if (op == 0 || op == 5)
        begin
            pin[k] = (op == 0) ? pa : pin[k];
            {retry[k], dis[k], blk[k]} = 4'hc;
        end
        else if (blk[k] || dis[k] != (op == 3))
            ex = 2;
        else if (pa === pin[k])
        begin
            retry[k] = 2'h3;
            pin[k] = (op == 1) ? pb : pin[k];
            dis[k] = (op == 2);
            nexp += (op != 1);
        end
        else
        begin
            ex = (retry[k] == 1) ? 4 : 1;
            blk[k] = (retry[k] == 1);
            retry[k] = retry[k] - (retry[k] != 0);
        end
        m = bad ? 7'h07 : 7'h7f;
        chk({sts[7:1] & m, 8'(nrev)}, {{blk[k], dis[k], retry[k], 3'(ex)} & m, 8'(nexp)});
    endtask
    task automatic query(input logic [16:0] q, input logic [31:0] exp);
        psch_terminal_i.wr(`PSCH_OFF_QUERY, {15'h0, q}, resp);
        cmd(3'h4, 8'h00, 8'h00, 8'h00, 64'h0);
        psch_terminal_i.rd(`PSCH_OFF_ACCESS, sts, resp);
        chk(sts, exp);
    endtask
    // hang guard
    initial
    begin
        #300us;
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a < 32; a += 4)
        begin
            psch_terminal_i.rd(8'(a), sts, resp);
            chk({sts, resp}, 40'h0);
        end
        psch_terminal_i.rd(8'h20, sts, resp);
        chk({sts, resp}, {32'h0, `PSCH_RESP_SLVERR});
        psch_terminal_i.wr(8'h24, rnd(), resp);
        chk(resp, `PSCH_RESP_SLVERR);
        $display("done reset and decode");
        cmd(3'h0, 8'h00, 8'h01, 8'h08, {rnd(), rnd()});
        cmd(3'h0, 8'h00, 8'h82, 8'h08, {rnd(), rnd()});
        cmd(3'h0, 8'h00, 8'h05, 8'h08, {rnd(), rnd()});
        cmd(3'h1, 8'h00, 8'h01, 8'h10, ~pin[1], {rnd(), rnd()});
        cmd(3'h1, 8'h00, 8'h01, 8'h10, pin[1], {rnd(), rnd()});
        foreach (badp[i])
            cmd(badp[i][26:24], badp[i][23:16], badp[i][15:8], badp[i][7:0], pin[1]);
        $display("done change and encodings");
        cmd(3'h2, 8'h85, 8'h01, 8'h08, ~pin[1]);
        cmd(3'h2, 8'h85, 8'h01, 8'h08, pin[1]);
        query(17'h00001, 32'h0500 | `PSCH_ACC_ALTERNATE);
        query(17'h12201, `PSCH_ACC_ALWAYS);
        query(17'h00005, {`PSCH_QUAL_USE, 16'h0});
        cmd(3'h2, 8'h00, 8'h01, 8'h08, pin[1]);
        cmd(3'h3, 8'h00, 8'h01, 8'h08, ~pin[1]);
        cmd(3'h3, 8'h00, 8'h01, 8'h08, pin[1]);
        query(17'h00001, `PSCH_ACC_VERIFY);
        query(17'h00005, 32'h0);
        cmd(3'h3, 8'h00, 8'h01, 8'h08, pin[1]);
        $display("done disable and enable");
        repeat (3) cmd(3'h2, 8'h00, 8'h82, 8'h08, ~pin[34]);
        query(17'h00022, `PSCH_ACC_NEVER);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmd(3'h2, 8'h00, 8'h82, 8'h08, pin[34]);
        cmd(3'h3, 8'h00, 8'h82, 8'h08, pin[34]);
        cmd(3'h2, 8'h00, 8'h01, 8'h08, pin[1]);
        repeat (3) cmd(3'h3, 8'h00, 8'h01, 8'h08, ~pin[1]);
        query(17'h00001, `PSCH_ACC_ALWAYS);
        cmd(3'h3, 8'h00, 8'h01, 8'h08, pin[1]);
        cmd(3'h5, 8'h00, 8'h01, 8'h08, 64'h0);
        $display("done blocking");
        report_and_stop();
    end
endmodule
bind psch_handler psch_monitor psch_monitor_i (.*);
